/* hdl/pvd_pkg.sv */
package pvd_pkg;

    // register map, one aligned word each
    localparam logic [7:0] ADDR_VALID_LEVEL = 8'h00;
    localparam logic [7:0] ADDR_ACCESS_CTRL = 8'h04;
    localparam logic [7:0] ADDR_MMU_STATUS  = 8'h08;
    localparam logic [7:0] ADDR_RESULT      = 8'h0C;
    localparam logic [7:0] ADDR_TRAP_DATA   = 8'h10;

    // access control fields
    localparam int CNT_LSB    = 0;
    localparam int CNT_WIDTH  = 2;
    localparam int MODE_BIT   = 8;

    // result register fields
    localparam int RES_ACT_LSB  = 0;
    localparam int RES_CNT_LSB  = 2;
    localparam int RES_BUSY_BIT = 4;

    // reset values
    localparam logic [7:0]  VALID_LEVEL_RST = 8'h00;
    localparam logic [1:0]  CNT_RST         = 2'h0;
    localparam logic        MODE_RST        = 1'b0;
    localparam logic [7:0]  STATUS_RST      = 8'h00;

    // access level position: top bits of the level register and address
    localparam int LEVEL_BITS     = 3;
    localparam int LEVEL_REG_MSB  = 7;
    localparam int ADDR_LEVEL_MSB = 15;

    // opcode patterns
    localparam logic [15:0] TRAP_OP_BASE = 16'hF078;
    localparam logic [15:0] TRAP_OP_MASK = 16'hFFF8;
    localparam logic [15:0] CHK_OP_BASE  = 16'hF000;
    localparam logic [15:0] CHK_OP_MASK  = 16'hFFC0;
    localparam logic [15:0] EXT_FORM1    = 16'h2800;
    localparam logic [15:0] EXT_FORM2    = 16'h2C00;
    localparam logic [15:0] EXT2_MASK    = 16'hFFF8;
    localparam logic [15:0] COND_MASK    = 16'hFFC0;
    localparam logic [5:0]  COND_MAX     = 6'h0F;

    // operand-form codes
    localparam logic [2:0] OPM_ONE  = 3'h2;
    localparam logic [2:0] OPM_TWO  = 3'h3;
    localparam logic [2:0] OPM_NONE = 3'h4;

    typedef enum logic [1:0] {
        ACT_CONTINUE, ACT_TRAP, ACT_ACCESS_EXC, ACT_LINE_F
    } pvd_action_e;

    typedef enum logic [2:0] {
        ST_IDLE, ST_COND, ST_OPER, ST_EXT, ST_EA_HI, ST_EA_LO, ST_REPORT
    } pvd_state_e;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } pvd_word_s;

    typedef struct packed {
        logic        done;
        pvd_action_e action;
        logic [1:0]  opCount;
        logic [31:0] opData;
    } pvd_result_s;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } pvd_apb_req_s;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } pvd_apb_rsp_s;

    function automatic logic pvd_opmode_legal(input logic [2:0] opm);
        return (opm == OPM_ONE) || (opm == OPM_TWO) || (opm == OPM_NONE);
    endfunction : pvd_opmode_legal

    function automatic logic [1:0] pvd_opmode_words(input logic [2:0] opm);
        return (opm == OPM_ONE) ? 2'h1 : ((opm == OPM_TWO) ? 2'h2 : 2'h0);
    endfunction : pvd_opmode_words

    // control-alterable modes only
    function automatic logic pvd_ea_legal(input logic [5:0] ea);
        return (ea[5:3] == 3'h2) || (ea[5:3] == 3'h5) || (ea[5:3] == 3'h6)
            || (ea[5:3] == 3'h7 && (ea[2:0] == 3'h0 || ea[2:0] == 3'h1));
    endfunction : pvd_ea_legal

endpackage : pvd_pkg

/* hdl/pvd_cond_eval.sv */
`timescale 1ns/1ps
module pvd_cond_eval (
    input  wire logic [7:0] statusFlags,
    input  wire logic [5:0] condField,
    output logic            condTrue
);
    // flag picked by bits 3:1, bit 0 inverts the sense (clear test)
    assign condTrue = statusFlags[condField[3:1]] ^ condField[0];
endmodule : pvd_cond_eval

/* hdl/pvd_level_compare.sv */
`timescale 1ns/1ps
module pvd_level_compare (
    input  wire logic [pvd_pkg::LEVEL_BITS-1:0] srcLevel,
    input  wire logic [pvd_pkg::LEVEL_BITS-1:0] dstLevel,
    input  wire logic [1:0]                     compareCount,
    output logic                                srcGreater
);
    logic [pvd_pkg::LEVEL_BITS-1:0] mask;

    // keep only the top compareCount bits
    for (genvar i = 0; i < pvd_pkg::LEVEL_BITS; i++) begin : g_mask
        assign mask[i] = compareCount > 2'(pvd_pkg::LEVEL_BITS - 1 - i);
    end

    // larger number means less privileged
    assign srcGreater = (srcLevel & mask) > (dstLevel & mask);
endmodule : pvd_level_compare

/* hdl/pvd_decoder.sv */
`timescale 1ns/1ps
// What this block does
// - true condition traps through coprocessor trap vector, next pc stacked
// - false condition does nothing, execution continues
// - six-bit field picks one of eight flags, bit 0 selects clear test
// - form 010 one operand word, 011 two, 100 none
// - condition field goes to the unit, which returns completion directive
// - trailing operand words fetched, not interpreted, kept for handler
// - neither instruction touches the memory-management status register
// - compare top source and destination level bits, count from control
// - source numerically greater raises access-level exception, else continue
// - level mode zero makes every validation with a legal addressing mode and extension word raise access-level exception
// - form one uses valid level register, form two an address register
// - only control-alterable addressing modes accepted for validated address
module pvd_decoder (
    input  wire logic                  core_clk,
    input  wire logic                  nrst,
    input  wire pvd_pkg::pvd_apb_req_s apbReq,
    output pvd_pkg::pvd_apb_rsp_s      apbRsp,
    input  wire pvd_pkg::pvd_word_s    instWord,
    output logic                       wordReady,
    input  wire logic [31:0]           aRegData,
    output logic [2:0]                 aRegSel,
    output pvd_pkg::pvd_result_s       result
);

    typedef struct packed {
        pvd_pkg::pvd_state_e   fsm;
        logic [7:0]            validLevel;
        logic [1:0]            cmpCount;
        logic                  levelMode;
        logic [7:0]            status;
        logic [1:0]            opLeft;
        logic [1:0]            opCount;
        logic [31:0]           opData;
        logic                  trapHit;
        logic                  condBad;
        logic                  eaOk;
        logic                  formTwo;
        logic [2:0]            aRegSel;
        logic [2:0]            srcLevel;
        logic [15:0]           eaHi;
        logic                  wordReady;
        pvd_pkg::pvd_result_s  res;
        pvd_pkg::pvd_apb_rsp_s rsp;
    } pvd_core_s;

    pvd_core_s   st;
    pvd_core_s   nx;
    logic        wordFire;
    logic        apbAccess;
    logic        apbCommit;
    logic        apbMapped;
    logic [31:0] readData;
    logic [15:0] w;
    logic        trapOp;
    logic        checkOp;
    logic        condWordLegal;
    logic        condTrue;
    logic        srcGreater;

    assign w         = instWord.data;
    assign wordFire  = instWord.valid && st.wordReady;
    assign apbAccess = apbReq.psel && apbReq.penable;
    // second access cycle: the edge at which the master sees pready
    assign apbCommit = apbAccess && st.rsp.pready;
    assign trapOp    = (w & pvd_pkg::TRAP_OP_MASK) == pvd_pkg::TRAP_OP_BASE;
    assign checkOp   = (w & pvd_pkg::CHK_OP_MASK) == pvd_pkg::CHK_OP_BASE;
    assign condWordLegal = ((w & pvd_pkg::COND_MASK) == 16'h0000)
                        && (w[5:0] <= pvd_pkg::COND_MAX);

    // flags read live from software's status copy
    pvd_cond_eval u_cond (
        .statusFlags (st.status),
        .condField   (w[5:0]),
        .condTrue    (condTrue)
    );

    // destination level is the top of the address under test
    pvd_level_compare u_level (
        .srcLevel     (st.srcLevel),
        .dstLevel     (st.eaHi[pvd_pkg::ADDR_LEVEL_MSB -: pvd_pkg::LEVEL_BITS]),
        .compareCount (st.cmpCount),
        .srcGreater   (srcGreater)
    );

    // register read mux, unmapped reads return zero with an error
    always_comb begin
        readData  = 32'h0000_0000;
        apbMapped = 1'b1;
        case (apbReq.paddr)
            pvd_pkg::ADDR_VALID_LEVEL: readData[7:0] = st.validLevel;
            pvd_pkg::ADDR_ACCESS_CTRL: begin
                readData[pvd_pkg::CNT_LSB +: pvd_pkg::CNT_WIDTH] = st.cmpCount;
                readData[pvd_pkg::MODE_BIT] = st.levelMode;
            end
            pvd_pkg::ADDR_MMU_STATUS:  readData[7:0] = st.status;
            pvd_pkg::ADDR_RESULT: begin
                readData[pvd_pkg::RES_ACT_LSB +: 2] = st.res.action;
                readData[pvd_pkg::RES_CNT_LSB +: 2] = st.res.opCount;
                readData[pvd_pkg::RES_BUSY_BIT] = st.fsm != pvd_pkg::ST_IDLE;
            end
            pvd_pkg::ADDR_TRAP_DATA:   readData = st.res.opData;
            default:                   apbMapped = 1'b0;
        endcase
    end

    // next state of the whole block
    always_comb begin
        nx = st;
        nx.res.done = 1'b0;
        // slave answers one cycle into the access phase
        nx.rsp.pready  = apbAccess && !st.rsp.pready;
        nx.rsp.prdata  = nx.rsp.pready ? readData : 32'h0000_0000;
        nx.rsp.pslverr = nx.rsp.pready && !apbMapped;
        // only software writes the status copy
        if (apbCommit && apbReq.pwrite) begin
            case (apbReq.paddr)
                pvd_pkg::ADDR_VALID_LEVEL: nx.validLevel = apbReq.pwdata[7:0];
                pvd_pkg::ADDR_ACCESS_CTRL: begin
                    nx.cmpCount = apbReq.pwdata[pvd_pkg::CNT_LSB +:
                                                pvd_pkg::CNT_WIDTH];
                    nx.levelMode = apbReq.pwdata[pvd_pkg::MODE_BIT];
                end
                pvd_pkg::ADDR_MMU_STATUS:  nx.status = apbReq.pwdata[7:0];
                default: ;
            endcase
        end

        unique case (st.fsm)
            pvd_pkg::ST_IDLE: begin
                if (wordFire) begin
                    nx.opData  = 32'h0000_0000;
                    nx.opCount = 2'h0;
                    nx.trapHit = 1'b0;
                    nx.condBad = 1'b0;
                    nx.eaOk    = 1'b1;
                    nx.formTwo = 1'b0;
                    if (trapOp && pvd_pkg::pvd_opmode_legal(w[2:0])) begin
                        nx.fsm     = pvd_pkg::ST_COND;
                        nx.opLeft  = pvd_pkg::pvd_opmode_words(w[2:0]);
                        nx.opCount = nx.opLeft;
                    end else if (checkOp) begin
                        nx.eaOk = pvd_pkg::pvd_ea_legal(w[5:0]);
                        nx.fsm  = pvd_pkg::ST_EXT;
                    end else begin
                        // bad form: no condition word is fetched
                        nx.res.action = pvd_pkg::ACT_LINE_F;
                        nx.fsm        = pvd_pkg::ST_REPORT;
                    end
                end
            end
            pvd_pkg::ST_COND: begin
                if (wordFire) begin
                    // decided now, later status writes cannot change it
                    nx.trapHit = condTrue;
                    nx.condBad = !condWordLegal;
                    if (st.opLeft == 2'h0) begin
                        nx.fsm = pvd_pkg::ST_REPORT;
                        nx.res.action = !condWordLegal ? pvd_pkg::ACT_LINE_F
                            : (condTrue ? pvd_pkg::ACT_TRAP
                                        : pvd_pkg::ACT_CONTINUE);
                    end else begin
                        nx.fsm = pvd_pkg::ST_OPER;
                    end
                end
            end
            pvd_pkg::ST_OPER: begin
                if (wordFire) begin
                    // most significant word arrives first, kept raw
                    nx.opData = {st.opData[15:0], w};
                    nx.opLeft = st.opLeft - 2'h1;
                    if (st.opLeft == 2'h1) begin
                        nx.fsm = pvd_pkg::ST_REPORT;
                        nx.res.action = st.condBad ? pvd_pkg::ACT_LINE_F
                            : (st.trapHit ? pvd_pkg::ACT_TRAP
                                          : pvd_pkg::ACT_CONTINUE);
                    end
                end
            end
            pvd_pkg::ST_EXT: begin
                if (wordFire) begin
                    nx.fsm = pvd_pkg::ST_EA_HI;
                    if ((w & pvd_pkg::EXT2_MASK) == pvd_pkg::EXT_FORM2) begin
                        nx.formTwo = 1'b1;
                        nx.aRegSel = w[2:0];
                    end else if (w != pvd_pkg::EXT_FORM1) begin
                        nx.eaOk = 1'b0;
                    end
                end
            end
            pvd_pkg::ST_EA_HI: begin
                if (wordFire) begin
                    nx.eaHi = w;
                    // address register read back one cycle after select
                    nx.srcLevel = st.formTwo
                        ? aRegData[31 -: pvd_pkg::LEVEL_BITS]
                        : st.validLevel[pvd_pkg::LEVEL_REG_MSB -:
                                        pvd_pkg::LEVEL_BITS];
                    nx.fsm = pvd_pkg::ST_EA_LO;
                end
            end
            pvd_pkg::ST_EA_LO: begin
                if (wordFire) begin
                    nx.fsm = pvd_pkg::ST_REPORT;
                    if (!st.eaOk) begin
                        nx.res.action = pvd_pkg::ACT_LINE_F;
                    end else if (!st.levelMode) begin
                        nx.res.action = pvd_pkg::ACT_ACCESS_EXC;
                    end else if (srcGreater) begin
                        nx.res.action = pvd_pkg::ACT_ACCESS_EXC;
                    end else begin
                        nx.res.action = pvd_pkg::ACT_CONTINUE;
                    end
                end
            end
            pvd_pkg::ST_REPORT: begin
                nx.fsm = pvd_pkg::ST_IDLE;
            end
        endcase

        // one-cycle result pulse, word intake stalls meanwhile
        if (nx.fsm == pvd_pkg::ST_REPORT) begin
            nx.res.done    = 1'b1;
            nx.res.opCount = nx.opCount;
            nx.res.opData  = nx.opData;
        end
        nx.wordReady = nx.fsm != pvd_pkg::ST_REPORT;
    end

    // single state register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st            <= '0;
            st.validLevel <= pvd_pkg::VALID_LEVEL_RST;
            st.cmpCount   <= pvd_pkg::CNT_RST;
            st.levelMode  <= pvd_pkg::MODE_RST;
            st.status     <= pvd_pkg::STATUS_RST;
        end else begin
            st <= nx;
        end
    end

    assign apbRsp    = st.rsp;
    assign wordReady = st.wordReady;
    assign aRegSel   = st.aRegSel;
    assign result    = st.res;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence condTake;
        wordFire && st.fsm == pvd_pkg::ST_COND && condWordLegal;
    endsequence

    sequence condLast;
        condTake ##0 (st.opLeft == 2'h0);
    endsequence

    sequence eaLast;
        wordFire && st.fsm == pvd_pkg::ST_EA_LO && st.eaOk;
    endsequence

    cond_trap_a: assert property (
        condLast ##0 condTrue
        |=> result.done && result.action == pvd_pkg::ACT_TRAP)
        else $error("true condition did not trap");

    cond_skip_a: assert property (
        condLast ##0 !condTrue
        |=> result.done && result.action == pvd_pkg::ACT_CONTINUE)
        else $error("false condition did not continue");

    cond_select_a: assert property (
        condTake |-> condTrue == (st.status[w[3:1]] ^ w[0]))
        else $error("wrong flag or sense selected");

    op_two_a: assert property (
        wordFire && st.fsm == pvd_pkg::ST_IDLE && trapOp
        && w[2:0] == pvd_pkg::OPM_TWO
        |=> st.fsm == pvd_pkg::ST_COND && st.opLeft == 2'h2)
        else $error("two-word form not decoded");

    op_none_a: assert property (
        wordFire && st.fsm == pvd_pkg::ST_IDLE && trapOp
        && w[2:0] == pvd_pkg::OPM_NONE
        |=> st.fsm == pvd_pkg::ST_COND && st.opLeft == 2'h0)
        else $error("no-operand form not decoded");

    bad_form_a: assert property (
        wordFire && st.fsm == pvd_pkg::ST_IDLE && trapOp
        && !pvd_pkg::pvd_opmode_legal(w[2:0])
        |=> result.done && result.action == pvd_pkg::ACT_LINE_F)
        else $error("undefined form not refused");

    operand_keep_a: assert property (
        wordFire && st.fsm == pvd_pkg::ST_OPER && st.opLeft == 2'h1
        |=> result.done && result.opData[15:0] == $past(w))
        else $error("operand word not kept");

    status_hold_a: assert property (
        !(apbCommit && apbReq.pwrite) |=> $stable(st.status))
        else $error("status changed without software write");

    mode_zero_a: assert property (
        eaLast ##0 !st.levelMode
        |=> result.done && result.action == pvd_pkg::ACT_ACCESS_EXC)
        else $error("mode zero did not raise exception");

    level_cmp_a: assert property (
        eaLast ##0 st.levelMode
        |=> result.action == ($past(srcGreater) ? pvd_pkg::ACT_ACCESS_EXC
                                                : pvd_pkg::ACT_CONTINUE))
        else $error("level comparison result wrong");

    count_zero_a: assert property (
        eaLast ##0 (st.levelMode && st.cmpCount == 2'h0)
        |=> result.action == pvd_pkg::ACT_CONTINUE)
        else $error("zero-bit compare must pass");

    reg_select_a: assert property (
        wordFire && st.fsm == pvd_pkg::ST_EXT
        && (w & pvd_pkg::EXT2_MASK) == pvd_pkg::EXT_FORM2
        |=> aRegSel == $past(w[2:0]))
        else $error("address register not selected");

    ea_mode_a: assert property (
        wordFire && st.fsm == pvd_pkg::ST_EA_LO && !st.eaOk
        |=> result.action == pvd_pkg::ACT_LINE_F)
        else $error("illegal mode accepted");

    apb_answer_a: assert property (
        apbAccess && !apbRsp.pready |=> apbRsp.pready ##1 !apbRsp.pready)
        else $error("apb answer timing wrong");

    cond_answer_a: assert property (
        condLast |=> result.done && !wordReady)
        else $error("no directive after condition word");

    done_pulse_a: assert property (
        result.done |=> !result.done && wordReady)
        else $error("result pulse not one cycle");

endmodule : pvd_decoder

/* testbench/pvd_core_model.sv */
`timescale 1ns/1ps
module pvd_core_model (
    input  wire logic          core_clk,
    input  wire logic          nrst,
    input  wire logic          wordReady,
    input  wire logic [2:0]    aRegSel,
    output pvd_pkg::pvd_word_s instWord,
    output logic [31:0]        aRegData
);
    logic [15:0] wordQ[$];
    logic [31:0] aRegs[8] = '{default: 32'h0};

    // words go out unaltered; addresses under test are the address itself
    function automatic void push(input logic [15:0] w);
        wordQ.push_back(w);
    endfunction : push

    // address register file, answered in the same cycle
    assign aRegData = aRegs[aRegSel];

    // idle data flips every cycle so a stale word never looks settled
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            instWord <= '0;
        end else begin
            if (instWord.valid && wordReady) begin
                void'(wordQ.pop_front());
            end
            if (wordQ.size() > 0) begin
                instWord <= {1'b1, wordQ[0]};
            end else begin
                instWord <= {1'b0, ~instWord.data};
            end
        end
    end
endmodule : pvd_core_model

/* testbench/tb.sv */
`timescale 1ns/1ps
module tb;
    logic                  core_clk;
    logic                  nrst;
    pvd_pkg::pvd_apb_req_s apbReq;
    pvd_pkg::pvd_apb_rsp_s apbRsp;
    pvd_pkg::pvd_word_s    instWord;
    logic                  wordReady;
    logic [31:0]           aRegData;
    logic [2:0]            aRegSel;
    pvd_pkg::pvd_result_s  result;
    int                    failures;
    int                    comparisons;
    logic [31:0]           rd;
    logic                  err;

    pvd_decoder i_pvd_decoder (.core_clk, .nrst, .apbReq, .apbRsp,
        .instWord, .wordReady, .aRegData, .aRegSel, .result);

    pvd_core_model core (.core_clk, .nrst, .wordReady, .aRegSel,
        .instWord, .aRegData);

    // 20 MHz
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic stop_test;
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; request held until pready is seen
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        int k;
        @(posedge core_clk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
                    pwdata: wd};
        @(posedge core_clk);
        apbReq.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (apbRsp.pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            failures++;
            stop_test();
        end
        // taken at the edge that saw pready high, released right after
        rd = apbRsp.prdata;
        err = apbRsp.pslverr;
        apbReq <= '0;
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
                         input logic expErr);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
        chk({31'h0, err}, {31'h0, expErr});
    endtask : rdchk

    // hand words to the core model and judge the outcome
    task automatic run(input logic [63:0] ws, input int n,
                       input logic [1:0] act, input logic [1:0] cnt,
                       input logic [31:0] od, input bit useD);
        int k;
        for (k = 0; k < n; k++) begin
            core.push(ws[63-16*k -: 16]);
        end
        k = 0;
        do begin
            @(negedge core_clk);
            k++;
        end while (result.done !== 1'b1 && k < 40);
        if (k >= 40) begin
            failures++;
            stop_test();
        end
        chk({30'h0, result.action}, {30'h0, act});
        chk({30'h0, result.opCount}, {30'h0, cnt});
        if (useD) begin
            chk(result.opData, od);
        end
    endtask : run

    task automatic vchk(input logic [5:0] ea, input logic [15:0] ext,
                        input logic [15:0] hi, input logic [1:0] act);
        run({10'h3C0, ea, ext, hi, 16'h0000}, 4, act, 2'h0, 32'h0, 1'b0);
    endtask : vchk

    task automatic t_regs;
        logic [7:0] a[5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
        foreach (a[i]) rdchk(a[i], 32'h0, 1'b0);
        rdchk(8'h14, 32'h0, 1'b1);
        apb(1'b1, pvd_pkg::ADDR_RESULT, 32'h0000000F);
        rdchk(pvd_pkg::ADDR_RESULT, 32'h0, 1'b0);
        apb(1'b1, pvd_pkg::ADDR_ACCESS_CTRL, 32'hFFFFFFFF);
        rdchk(pvd_pkg::ADDR_ACCESS_CTRL, 32'h00000103, 1'b0);
    endtask : t_regs

    // both polarities of every flag, two status patterns
    task automatic t_trap_cond;
        logic [7:0] st;
        logic [5:0] c;
        logic [1:0] e;
        for (int s = 0; s < 2; s++) begin
            st = (s != 0) ? 8'h5A : 8'hA5;
            apb(1'b1, pvd_pkg::ADDR_MMU_STATUS, {24'h0, st});
            for (int i = 0; i < 16; i++) begin
                c = 6'(i);
                e = (st[c[3:1]] ^ c[0]) ? pvd_pkg::ACT_TRAP
                                        : pvd_pkg::ACT_CONTINUE;
                run({16'hF07C, 10'h0, c, 32'h0}, 2, e, 2'h0, 32'h0,
                    1'b0);
            end
            rdchk(pvd_pkg::ADDR_MMU_STATUS, {24'h0, st}, 1'b0);
        end
    endtask : t_trap_cond

    // status is 5A here: bus error flag clear
    task automatic t_trap_forms;
        run({16'hF07A, 16'h0000, 16'h1234, 16'h0}, 3,
            pvd_pkg::ACT_CONTINUE, 2'h1, 32'h1234, 1'b1);
        run({16'hF07B, 16'h0001, 16'hBEEF, 16'hCAFE}, 4,
            pvd_pkg::ACT_TRAP, 2'h2, 32'hBEEFCAFE, 1'b1);
        rdchk(pvd_pkg::ADDR_RESULT, 32'h9, 1'b0);
        rdchk(pvd_pkg::ADDR_TRAP_DATA, 32'hBEEFCAFE, 1'b0);
        run({16'hF07C, 16'h0010, 32'h0}, 2, pvd_pkg::ACT_LINE_F, 2'h0,
            32'h0, 1'b0);
    endtask : t_trap_forms

    task automatic t_bad_form;
        logic [2:0] b[5] = '{3'h0, 3'h1, 3'h5, 3'h6, 3'h7};
        foreach (b[i]) begin
            run({13'h1E0F, b[i], 48'h0}, 1, pvd_pkg::ACT_LINE_F, 2'h0,
                32'h0, 1'b0);
        end
    endtask : t_bad_form

    // source level 5 against every destination, every compare width
    task automatic t_level;
        logic [1:0] e;
        apb(1'b1, pvd_pkg::ADDR_VALID_LEVEL, 32'h000000A0);
        for (int n = 0; n < 4; n++) begin
            apb(1'b1, pvd_pkg::ADDR_ACCESS_CTRL, 32'h100 | n);
            for (int d = 0; d < 8; d++) begin
                e = (n > 0 && (5 >> (3 - n)) > (d >> (3 - n)))
                    ? pvd_pkg::ACT_ACCESS_EXC : pvd_pkg::ACT_CONTINUE;
                vchk(6'h10, 16'h2800, {3'(d), 13'h0}, e);
            end
        end
        rdchk(pvd_pkg::ADDR_MMU_STATUS, 32'h5A, 1'b0);
        apb(1'b1, pvd_pkg::ADDR_ACCESS_CTRL, 32'h3);
        vchk(6'h10, 16'h2800, 16'hE000, pvd_pkg::ACT_ACCESS_EXC);
        apb(1'b1, pvd_pkg::ADDR_ACCESS_CTRL, 32'h0);
        vchk(6'h10, 16'h2800, 16'hE000, pvd_pkg::ACT_ACCESS_EXC);
    endtask : t_level

    // register source differs from the level register on purpose
    task automatic t_form2;
        apb(1'b1, pvd_pkg::ADDR_ACCESS_CTRL, 32'h103);
        core.aRegs[3] = {3'h2, 29'h0};
        core.aRegs[4] = {3'h7, 29'h0};
        vchk(6'h28, 16'h2C03, 16'h2000, pvd_pkg::ACT_ACCESS_EXC);
        vchk(6'h28, 16'h2C03, 16'h4000, pvd_pkg::ACT_CONTINUE);
        vchk(6'h28, 16'h2C04, 16'hC000, pvd_pkg::ACT_ACCESS_EXC);
    endtask : t_form2

    task automatic t_ea;
        logic [5:0] ok[5] = '{6'h10, 6'h28, 6'h30, 6'h38, 6'h39};
        logic [5:0] bad[6] = '{6'h00, 6'h08, 6'h18, 6'h20, 6'h3A, 6'h3C};
        apb(1'b1, pvd_pkg::ADDR_VALID_LEVEL, 32'h0);
        foreach (ok[i]) vchk(ok[i], 16'h2800, 16'h0, 2'h0);
        foreach (bad[i]) vchk(bad[i], 16'h2800, 16'h0, 2'h3);
    endtask : t_ea

    initial begin
        failures = 0;
        comparisons = 0;
        apbReq = '0;
        nrst = 1'b0;
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge core_clk);
        t_regs();
        t_trap_cond();
        t_trap_forms();
        t_bad_form();
        t_level();
        t_form2();
        t_ea();
        stop_test();
    end
endmodule : tb
